// File: hdl/afe_cfg_map.svh
// register offsets, field positions and reset values of the front-end config bank
// assumes inclusion by bare name; definitions only
`ifndef AFE_CFG_MAP_SVH
`define AFE_CFG_MAP_SVH
// ------------------------------------------------------------
// offsets
// ------------------------------------------------------------
`define AFE_OFS_CAL 16'h0701
`define AFE_OFS_REF 16'h18A6
`define AFE_OFS_CMB 16'h18E3
`define AFE_OFS_TDE 16'h18E6
`define AFE_OFS_CPL 16'h1908
`define AFE_OFS_FS 16'h1910
// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define AFE_RST_CAL 8'h06
`define AFE_CAL_DIS 8'h06
`define AFE_CAL_EN 8'h86
`define AFE_RST_REF 1'h0
`define AFE_RST_CMB_EN 1'h0
`define AFE_RST_CMB_LVL 6'h00
`define AFE_RST_TDE 8'h00
`define AFE_RST_CPL 1'h0
`define AFE_RST_FS 4'hD
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define AFE_REF_BIT 0
`define AFE_CMB_EN_BIT 6
`define AFE_CMB_LVL_MSB 5
`define AFE_CPL_BIT 2
`define AFE_FS_MSB 3
`define AFE_TDE_SRC_MSB 7
`define AFE_TDE_SRC_LSB 4
`define AFE_TDE_SRC_CEN 4'h0
`define AFE_TDE_SRC_A 4'h4
`define AFE_TDE_SRC_B 4'h5
`define AFE_TDE_MODE_MSB 1
`endif

// File: hdl/afe_pkg.sv
// types shared by the front-end config bank
// assumes nothing beyond a SystemVerilog compiler
package afe_pkg;
  typedef enum logic [2:0] {
    AFE_DIODE_NONE = 3'h1,
    AFE_DIODE_CENTRAL = 3'h2,
    AFE_DIODE_CHAN_A = 3'h4
  } afe_dsel_dummy_t;
  typedef enum logic [3:0] {
    AFE_DS_OFF = 4'h1,
    AFE_DS_CENTRAL = 4'h2,
    AFE_DS_CHAN_A = 4'h4,
    AFE_DS_CHAN_B = 4'h8
  } afe_diode_t;
  typedef enum logic [3:0] {
    AFE_PIN_HIZ = 4'h1,
    AFE_PIN_X1 = 4'h2,
    AFE_PIN_X20 = 4'h4,
    AFE_PIN_GND = 4'h8
  } afe_pin_t;
endpackage

// File: hdl/afe_diode_dec.sv
// decoder of the temperature diode export code into source and pin mode
// assumes a stored 8-bit code; purely combinational
`timescale 1ns/1ps
`include "afe_cfg_map.svh"
module afe_diode_dec
  import afe_pkg::*;
(
  input wire logic [7:0] code,
  output afe_diode_t diode_src,
  output afe_pin_t pin_mode
);
  // ------------------------------------------------------------
  // source and pin decode
  // ------------------------------------------------------------
  logic [3:0] src_field;
  logic listed;
  assign src_field = code[`AFE_TDE_SRC_MSB:`AFE_TDE_SRC_LSB];
  assign listed = (code[3:2] == 2'h0);

  // codes with bits 3:2 nonzero park on diode off, high-Z
  always_comb begin
    diode_src = AFE_DS_OFF;
    pin_mode = AFE_PIN_HIZ;
    if (listed) begin
      unique case (src_field)
        `AFE_TDE_SRC_CEN: diode_src = AFE_DS_CENTRAL;
        `AFE_TDE_SRC_A: diode_src = AFE_DS_CHAN_A;
        `AFE_TDE_SRC_B: diode_src = AFE_DS_CHAN_B;
        default: diode_src = AFE_DS_OFF;
      endcase
      unique case (code[`AFE_TDE_MODE_MSB:0])
        2'h0: pin_mode = (src_field == `AFE_TDE_SRC_CEN) ? AFE_PIN_X1 : AFE_PIN_HIZ;
        2'h1: pin_mode = AFE_PIN_X1;
        2'h2: pin_mode = AFE_PIN_X20;
        2'h3: pin_mode = AFE_PIN_GND;
      endcase
    end
  end
endmodule

// File: hdl/afe_cfg_regs.sv
// configuration register bank steering the analog front end
// assumes a plain register port: strobes one cycle, read data the next cycle
//
// Function
// - calibration register resets to disable code; enable/disable codes written freely
// - diode code resets zero, central diode; 0x02 twenty times, 0x03 ground
// - codes 0x40 to 0x43 pick channel A diode, four pin modes
// - codes 0x50 to 0x53 pick channel B diode, four pin modes
// - coupling bit two: 0 ac optimised, 1 dc optimised
// - full-scale trim resets to 0xD, 1.7 V, upper bits reserved
// - trim codes map to the printed full-scale voltages
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "afe_cfg_map.svh"
module afe_cfg_regs
  import afe_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic offset_cal_enable,
  output logic ext_reference_sel,
  output logic cm_buffer_enable,
  output logic [5:0] common_mode_level,
  output afe_diode_t diode_src,
  output afe_pin_t diode_pin_mode,
  output logic dc_coupling_opt,
  output logic [3:0] full_scale_trim
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0] cal_reg, next_cal_reg;
  logic ref_reg, next_ref_reg;
  logic cmb_en, next_cmb_en;
  logic [5:0] cmb_lvl, next_cmb_lvl;
  logic [7:0] tde_reg, next_tde_reg;
  logic cpl_reg, next_cpl_reg;
  logic [3:0] fs_reg, next_fs_reg;
  logic [7:0] next_rdata;

  // one-hot address match, shared by write and read paths
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  // next values: writes land, reserved bits dropped
  always_comb begin
    next_cal_reg = cal_reg;
    next_ref_reg = ref_reg;
    next_cmb_en = cmb_en;
    next_cmb_lvl = cmb_lvl;
    next_tde_reg = tde_reg;
    next_cpl_reg = cpl_reg;
    next_fs_reg = fs_reg;
    if (reg_wr) begin
      if (hit(reg_addr, `AFE_OFS_CAL)) next_cal_reg = reg_wdata;
      if (hit(reg_addr, `AFE_OFS_REF)) next_ref_reg = reg_wdata[`AFE_REF_BIT];
      if (hit(reg_addr, `AFE_OFS_CMB)) begin
        next_cmb_en = reg_wdata[`AFE_CMB_EN_BIT];
        next_cmb_lvl = reg_wdata[`AFE_CMB_LVL_MSB:0];
      end
      if (hit(reg_addr, `AFE_OFS_TDE)) next_tde_reg = reg_wdata;
      if (hit(reg_addr, `AFE_OFS_CPL)) next_cpl_reg = reg_wdata[`AFE_CPL_BIT];
      if (hit(reg_addr, `AFE_OFS_FS)) next_fs_reg = reg_wdata[`AFE_FS_MSB:0];
    end
  end

  // read mux, reserved and unmapped read zero
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      if (hit(reg_addr, `AFE_OFS_CAL)) next_rdata = cal_reg;
      if (hit(reg_addr, `AFE_OFS_REF)) next_rdata = {7'h00, ref_reg};
      if (hit(reg_addr, `AFE_OFS_CMB)) next_rdata = {1'h0, cmb_en, cmb_lvl};
      if (hit(reg_addr, `AFE_OFS_TDE)) next_rdata = tde_reg;
      if (hit(reg_addr, `AFE_OFS_CPL)) next_rdata = {5'h00, cpl_reg, 2'h0};
      if (hit(reg_addr, `AFE_OFS_FS)) next_rdata = {4'h0, fs_reg};
    end
  end

  // state registers with reset values
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cal_reg <= `AFE_RST_CAL;
      ref_reg <= `AFE_RST_REF;
      cmb_en <= `AFE_RST_CMB_EN;
      cmb_lvl <= `AFE_RST_CMB_LVL;
      tde_reg <= `AFE_RST_TDE;
      cpl_reg <= `AFE_RST_CPL;
      fs_reg <= `AFE_RST_FS;
      reg_rdata <= 8'h00;
    end else begin
      cal_reg <= next_cal_reg;
      ref_reg <= next_ref_reg;
      cmb_en <= next_cmb_en;
      cmb_lvl <= next_cmb_lvl;
      tde_reg <= next_tde_reg;
      cpl_reg <= next_cpl_reg;
      fs_reg <= next_fs_reg;
      reg_rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // analog control outputs
  // ------------------------------------------------------------
  assign offset_cal_enable = (cal_reg == `AFE_CAL_EN);
  assign ext_reference_sel = ref_reg;
  assign cm_buffer_enable = cmb_en;
  assign common_mode_level = cmb_lvl;
  assign dc_coupling_opt = cpl_reg;
  assign full_scale_trim = fs_reg;

  // diode routing decode
  afe_diode_dec u_dec (
    .code(tde_reg),
    .diode_src(diode_src),
    .pin_mode(diode_pin_mode)
  );
endmodule

// File: dv/afe_cfg_regs_checker.sv
// port assertions for the front-end config bank
// assumes bind onto afe_cfg_regs, one clock, sync reset
`timescale 1ns/1ps
module afe_cfg_checker
  import afe_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic offset_cal_enable,
  input wire logic ext_reference_sel,
  input wire logic cm_buffer_enable,
  input wire logic [5:0] common_mode_level,
  input afe_diode_t diode_src,
  input afe_pin_t diode_pin_mode,
  input wire logic dc_coupling_opt,
  input wire logic [3:0] full_scale_trim
);
  // ----
  // checks
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_cal_code: assert property (
    reg_wr && reg_addr == 16'h0701 |=> offset_cal_enable == ($past(reg_wdata) == 8'h86))
    else $error("cal enable wrong");
  a_ref_bit: assert property (
    reg_wr && reg_addr == 16'h18A6 |=> ext_reference_sel == $past(reg_wdata[0]))
    else $error("ref select wrong");
  a_cm_fields: assert property (
    reg_wr && reg_addr == 16'h18E3 |=>
    {cm_buffer_enable, common_mode_level} == $past(reg_wdata[6:0]))
    else $error("cm buffer wrong");
  a_diode_gnd: assert property (
    reg_wr && reg_addr == 16'h18E6 && reg_wdata == 8'h03 |=>
    diode_src == AFE_DS_CENTRAL && diode_pin_mode == AFE_PIN_GND) else $error("central gnd wrong");
  a_diode_chan_a: assert property (
    reg_wr && reg_addr == 16'h18E6 && reg_wdata[7:2] == 6'h10 |=> diode_src == AFE_DS_CHAN_A
    && diode_pin_mode == 4'h1 << $past(reg_wdata[1:0])) else $error("chan a diode wrong");
  a_diode_chan_b: assert property (
    reg_wr && reg_addr == 16'h18E6 && reg_wdata[7:2] == 6'h14 |=> diode_src == AFE_DS_CHAN_B
    && diode_pin_mode == 4'h1 << $past(reg_wdata[1:0])) else $error("chan b diode wrong");
  a_dc_bit: assert property (
    reg_wr && reg_addr == 16'h1908 |=> dc_coupling_opt == $past(reg_wdata[2]))
    else $error("coupling wrong");
  a_trim_field: assert property (
    reg_wr && reg_addr == 16'h1910 |=> full_scale_trim == $past(reg_wdata[3:0]))
    else $error("trim wrong");
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
endmodule
bind afe_cfg_regs afe_cfg_checker afe_cfg_checker_i (.mclk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .offset_cal_enable, .ext_reference_sel, .cm_buffer_enable,
  .common_mode_level, .diode_src, .diode_pin_mode, .dc_coupling_opt, .full_scale_trim);

// File: dv/test_afe_cfg_regs.sv
// self-checking bench for the front-end config bank
// assumes the register port answers reads one cycle later
`timescale 1ns/1ps
module test_afe_cfg_regs;
  import afe_pkg::*;
  typedef struct {logic [15:0] a; logic [7:0] d, r, b;} afe_row_t;
  logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
  logic [15:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic offset_cal_enable, ext_reference_sel, cm_buffer_enable, dc_coupling_opt;
  logic [5:0] common_mode_level;
  logic [3:0] full_scale_trim, ep;
  afe_diode_t diode_src;
  afe_pin_t diode_pin_mode;
  int n_mismatch = 0, n_tests = 0;
  // address, write, reset value, readback
  afe_row_t rows [9] = '{'{16'h0701, 8'h86, 8'h06, 8'h86}, '{16'h0701, 8'h06, 8'h06, 8'h06},
    '{16'h18A6, 8'hFF, 8'h00, 8'h01}, '{16'h18E3, 8'hFF, 8'h00, 8'h7F},
    '{16'h18E6, 8'hA5, 8'h00, 8'hA5}, '{16'h1908, 8'hFF, 8'h00, 8'h04},
    '{16'h1910, 8'hF8, 8'h0D, 8'h08}, '{16'h1910, 8'h00, 8'h0D, 8'h00},
    '{16'h0702, 8'hFF, 8'h00, 8'h00}};
  logic [7:0] cd [11] = '{8'h00, 8'h02, 8'h03, 8'h40, 8'h41, 8'h42, 8'h43,
    8'h50, 8'h51, 8'h52, 8'h53};
  always #5 mclk = ~mclk;
  afe_cfg_regs afe_cfg_regs_i (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .offset_cal_enable, .ext_reference_sel, .cm_buffer_enable, .common_mode_level,
    .diode_src, .diode_pin_mode, .dc_coupling_opt, .full_scale_trim);
  // ----
  // tasks
  // ----
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge mclk);
    reg_wr <= 0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge mclk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask
  task wrap_up;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 0;
    foreach (rows[i]) rd(rows[i].a, rows[i].r);
    chk({diode_src, diode_pin_mode}, 8'h22);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].b);
    end
    chk({ext_reference_sel, cm_buffer_enable, common_mode_level}, 8'hFF);
    chk({7'h0, dc_coupling_opt}, 8'h01);
    chk({4'h0, full_scale_trim}, 8'h00);
    wr(16'h0701, 8'h86);
    #1 chk({7'h0, offset_cal_enable}, 8'h01);
    foreach (cd[i]) begin
      wr(16'h18E6, cd[i]);
      ep = cd[i] == 8'h00 ? 4'h2 : 4'h1 << cd[i][1:0];
      #1;
      chk({diode_src, diode_pin_mode},
        {cd[i][4] ? 4'h8 : cd[i][6] ? 4'h4 : 4'h2, ep});
    end
    wr(16'h1910, 8'h08);
    sys_rst <= 1;
    @(posedge mclk);
    sys_rst <= 0;
    #1 chk({3'h0, offset_cal_enable, full_scale_trim}, 8'h0D);
    wrap_up();
  end
endmodule
